// >>> common/rvsr_pkg.sv
// package: register offsets, layouts and voltage decode constants
package rvsr_pkg;
	// ------------------------------------------------------------
	// register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SETPOINT_ADDR = 8'h02;
	localparam logic [7:0] STATUS_ADDR = 8'h03;
	localparam logic [7:0] SETPOINT_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// ------------------------------------------------------------
	// status bit positions
	// ------------------------------------------------------------
	localparam int WARN_BIT = 7;
	localparam int ON_BIT = 6;
	localparam int BOOT_BIT = 5;
	localparam int RAMP_BIT = 4;
	localparam int HICCUP_BIT = 3;
	localparam int THERMAL_BIT = 2;
	localparam int LATCH_BIT = 1;
	localparam int GOOD_BIT = 0;
	// ------------------------------------------------------------
	// voltage decode, millivolts
	// ------------------------------------------------------------
	localparam logic [7:0] FLOOR_TOP_CODE = 8'h3B;
	localparam logic [7:0] FINE_BASE_CODE = 8'h3C;
	localparam logic [7:0] COARSE_BASE_CODE = 8'h80;
	localparam logic [11:0] FLOOR_MV = 12'h258;
	localparam logic [11:0] FINE_BASE_MV = 12'h262;
	localparam logic [11:0] FINE_STEP_MV = 12'h00A;
	localparam logic [11:0] COARSE_BASE_MV = 12'h514;
	localparam logic [11:0] COARSE_STEP_MV = 12'h014;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic thermal_warning_flag;
		logic converter_on;
		logic boot_error;
		logic ramp_complete_flag;
		logic hiccup_active;
		logic thermal_fault_flag;
		logic latched_off;
		logic output_good_flag;
	} rvsr_cond_t;
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rvsr_req_t;
endpackage

// >>> design/rvsr_regs.sv
// regulator setpoint and status register bank
`timescale 1ns/1ps
// ------------------------------------------------------------
// Overview of operation
// R1 - codes 0x00 to 0x3B give the 0.6 V floor target
// R2 - codes 0x3C to 0x7F step 10 mV from 0.61 V to 1.28 V
// R3 - codes 0x80 to 0xFF step 20 mV from 1.3 V to 3.84 V
// R4 - status register is eight read-only bits, zero after power-on
// R5 - bit 7 shows thermal warning
// R6 - bit 6 shows converter on
// R7 - bit 5 shows boot-up fault
// R8 - bit 4 shows soft-start ramp complete
// R9 - bit 3 shows current-limit hiccup
// R10 - bit 2 shows overtemperature fault
// R11 - bit 1 shows output latched off
// R12 - bit 0 shows output power good
// R13 - host reaches registers by byte address from the two-wire engine
// R14 - host writes to status are ignored
// R15 - setpoint is read/write, returns last write, resets to zero
// ------------------------------------------------------------
module rvsr_regs (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire rvsr_pkg::rvsr_req_t req_in,
	input wire rvsr_pkg::rvsr_cond_t cond_in,
	output logic [7:0] rdata_out,
	output logic rvalid_out,
	output logic [7:0] voltage_code_out,
	output logic [11:0] target_mv_out
);
	// ------------------------------------------------------------
	// condition synchronisers
	// ------------------------------------------------------------
	// conditions come from the analog loop, so two flops first
	logic [7:0] sync1_q, sync1_d;
	logic [7:0] status_q, status_d;
	logic [7:0] setpoint_q, setpoint_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [11:0] mv_q, mv_d;
	logic [11:0] fine_off;
	logic [11:0] coarse_off;

	always_comb
	begin
		sync1_d = cond_in;
		status_d = sync1_q; // R4 R5 R6 R7 R8 R9 R10 R11 R12
	end

	// ------------------------------------------------------------
	// register access
	// ------------------------------------------------------------
	always_comb
	begin
		setpoint_d = setpoint_q;
		rdata_d = rdata_q;
		rvalid_d = req_in.rd_en;
		// R14: status has no write path at all
		if (req_in.wr_en && req_in.addr == rvsr_pkg::SETPOINT_ADDR) // R13
			setpoint_d = req_in.wdata; // R15
		if (req_in.rd_en)
		begin
			case (req_in.addr) // R13
				rvsr_pkg::SETPOINT_ADDR: rdata_d = setpoint_q; // R15
				rvsr_pkg::STATUS_ADDR: rdata_d = status_q; // R4
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// voltage decode
	// ------------------------------------------------------------
	// multiply-free: step times offset is small, tools fold it
	always_comb
	begin
		fine_off = 12'({4'h0, setpoint_q} - {4'h0, rvsr_pkg::FINE_BASE_CODE});
		coarse_off = 12'({4'h0, setpoint_q}
			- {4'h0, rvsr_pkg::COARSE_BASE_CODE});
		if (setpoint_q <= rvsr_pkg::FLOOR_TOP_CODE)
			mv_d = rvsr_pkg::FLOOR_MV; // R1
		else if (setpoint_q < rvsr_pkg::COARSE_BASE_CODE)
			mv_d = 12'(rvsr_pkg::FINE_BASE_MV
				+ fine_off * rvsr_pkg::FINE_STEP_MV); // R2
		else
			mv_d = 12'(rvsr_pkg::COARSE_BASE_MV
				+ coarse_off * rvsr_pkg::COARSE_STEP_MV); // R3
	end

	// ------------------------------------------------------------
	// state registers, one process per group
	// ------------------------------------------------------------
	// both stages clear, so status reads zero at once after reset
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			sync1_q <= rvsr_pkg::STATUS_RESET;
			status_q <= rvsr_pkg::STATUS_RESET; // R4
		end
		else
		begin
			sync1_q <= sync1_d;
			status_q <= status_d;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			setpoint_q <= rvsr_pkg::SETPOINT_RESET; // R15
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end
		else
		begin
			setpoint_q <= setpoint_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// target resets to the floor, matching the zero code
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			mv_q <= rvsr_pkg::FLOOR_MV; // R1
		end
		else
		begin
			mv_q <= mv_d;
		end
	end

	assign rdata_out = rdata_q;
	assign rvalid_out = rvalid_q;
	assign voltage_code_out = setpoint_q;
	assign target_mv_out = mv_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	chk_floor_target: assert property ( // R1
		setpoint_q <= 8'h3B |=> mv_q == 12'd600)
		else $error("floor target wrong");
	chk_fine_step: assert property ( // R2
		setpoint_q >= 8'h3C && setpoint_q <= 8'h7F
		|=> mv_q == 12'(610 + 10 * (int'($past(setpoint_q)) - 60)))
		else $error("fine step target wrong");
	chk_coarse_step: assert property ( // R3
		setpoint_q >= 8'h80
		|=> mv_q == 12'(1300 + 20 * (int'($past(setpoint_q)) - 128)))
		else $error("coarse step target wrong");
	chk_status_follow: assert property ( // R5
		1'b1 |-> ##2 status_q == $past(cond_in, 2))
		else $error("status does not follow conditions");
	chk_status_read: assert property ( // R4
		req_in.rd_en && req_in.addr == 8'h03 |=> rdata_q == $past(status_q))
		else $error("status read value wrong");
	chk_status_nowrite: assert property ( // R14
		req_in.wr_en && req_in.addr == 8'h03
		|-> ##2 status_q == $past(cond_in, 2))
		else $error("status write had effect");
	chk_setpoint_write: assert property ( // R15
		req_in.wr_en && req_in.addr == 8'h02 |=> setpoint_q == $past(req_in.wdata))
		else $error("setpoint write lost");
	chk_setpoint_hold: assert property ( // R15
		!(req_in.wr_en && req_in.addr == 8'h02) |=> $stable(setpoint_q))
		else $error("setpoint changed without write");
	chk_read_valid: assert property ( // R13
		req_in.rd_en |=> rvalid_q ##1 1'b1)
		else $error("read answer missing");
	chk_unmapped_read: assert property ( // R13
		req_in.rd_en && req_in.addr > 8'h03 |=> rdata_q == 8'h00)
		else $error("unmapped read not zero");

	// ------------------------------------------------------------
	// decode end points, middle points and target range
	// ------------------------------------------------------------
	chk_floor_bottom: assert property ( // R1
		setpoint_q == 8'h00 |=> mv_q == rvsr_pkg::FLOOR_MV)
		else $error("bottom code target wrong");

	chk_floor_top: assert property ( // R1
		setpoint_q == rvsr_pkg::FLOOR_TOP_CODE |=> mv_q == rvsr_pkg::FLOOR_MV)
		else $error("floor top code target wrong");

	chk_fine_first: assert property ( // R2
		setpoint_q == rvsr_pkg::FINE_BASE_CODE |=> mv_q == rvsr_pkg::FINE_BASE_MV)
		else $error("first fine code target wrong");

	chk_fine_mid: assert property ( // R2
		setpoint_q == 8'h5F |=> mv_q == 12'h3C0)
		else $error("middle fine code target wrong");

	chk_fine_last: assert property ( // R2
		setpoint_q == 8'h7F |=> mv_q == 12'h500)
		else $error("last fine code target wrong");

	chk_coarse_first: assert property ( // R3
		setpoint_q == rvsr_pkg::COARSE_BASE_CODE
		|=> mv_q == rvsr_pkg::COARSE_BASE_MV)
		else $error("first coarse code target wrong");

	chk_coarse_mid: assert property ( // R3
		setpoint_q == 8'hC0 |=> mv_q == 12'hA14)
		else $error("middle coarse code target wrong");

	chk_coarse_last: assert property ( // R3
		setpoint_q == 8'hFF |=> mv_q == 12'hF00)
		else $error("top code target wrong");

	chk_target_range: assert property ( // R3
		mv_q >= rvsr_pkg::FLOOR_MV && mv_q <= 12'hF00)
		else $error("target outside range");

	// ------------------------------------------------------------
	// status bits
	// ------------------------------------------------------------
	// two synchroniser stages, so each bit lags its condition by two edges
	chk_warn_bit: assert property ( // R5
		1'b1 |-> ##2 status_q[rvsr_pkg::WARN_BIT]
		== $past(cond_in.thermal_warning_flag, 2))
		else $error("warning bit wrong");

	chk_on_bit: assert property ( // R6
		1'b1 |-> ##2 status_q[rvsr_pkg::ON_BIT]
		== $past(cond_in.converter_on, 2))
		else $error("on bit wrong");

	chk_boot_bit: assert property ( // R7
		1'b1 |-> ##2 status_q[rvsr_pkg::BOOT_BIT]
		== $past(cond_in.boot_error, 2))
		else $error("boot bit wrong");

	chk_ramp_bit: assert property ( // R8
		1'b1 |-> ##2 status_q[rvsr_pkg::RAMP_BIT]
		== $past(cond_in.ramp_complete_flag, 2))
		else $error("ramp bit wrong");

	chk_hiccup_bit: assert property ( // R9
		1'b1 |-> ##2 status_q[rvsr_pkg::HICCUP_BIT]
		== $past(cond_in.hiccup_active, 2))
		else $error("hiccup bit wrong");

	chk_thermal_bit: assert property ( // R10
		1'b1 |-> ##2 status_q[rvsr_pkg::THERMAL_BIT]
		== $past(cond_in.thermal_fault_flag, 2))
		else $error("thermal bit wrong");

	chk_latch_bit: assert property ( // R11
		1'b1 |-> ##2 status_q[rvsr_pkg::LATCH_BIT]
		== $past(cond_in.latched_off, 2))
		else $error("latch bit wrong");

	chk_good_bit: assert property ( // R12
		1'b1 |-> ##2 status_q[rvsr_pkg::GOOD_BIT]
		== $past(cond_in.output_good_flag, 2))
		else $error("good bit wrong");

	chk_sync_first: assert property ( // R4
		1'b1 |=> sync1_q == $past(cond_in))
		else $error("first sync stage wrong");

	// ------------------------------------------------------------
	// access path
	// ------------------------------------------------------------
	chk_setpoint_read: assert property ( // R15
		req_in.rd_en && req_in.addr == rvsr_pkg::SETPOINT_ADDR
		|=> rdata_q == $past(setpoint_q))
		else $error("setpoint read value wrong");

	chk_rdata_hold: assert property ( // R13
		!req_in.rd_en |=> $stable(rdata_q))
		else $error("read data moved without read");

	chk_rvalid_pulse: assert property ( // R13
		!req_in.rd_en |=> !rvalid_q)
		else $error("read answer without read");

	chk_low_unmapped: assert property ( // R13
		req_in.rd_en && req_in.addr < rvsr_pkg::SETPOINT_ADDR
		|=> rdata_q == 8'h00)
		else $error("low unmapped read not zero");

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	// checked while reset is high, so the default disable is overridden
	chk_reset_clear: assert property ( // R4
		disable iff (1'b0)
		reset_in |=> status_q == rvsr_pkg::STATUS_RESET
		&& setpoint_q == rvsr_pkg::SETPOINT_RESET && !rvalid_q)
		else $error("reset did not clear registers");

	chk_reset_target: assert property ( // R1
		disable iff (1'b0)
		reset_in |=> mv_q == rvsr_pkg::FLOOR_MV)
		else $error("reset target not floor");

	cov_fine_write: cover property (
		req_in.wr_en && req_in.addr == 8'h02 && req_in.wdata == 8'h3C);
	cov_coarse_write: cover property (
		req_in.wr_en && req_in.addr == 8'h02 && req_in.wdata == 8'hFF);
	cov_status_read: cover property (
		req_in.rd_en && req_in.addr == 8'h03 ##1 rdata_q != 8'h00);
	cov_floor_write: cover property (
		req_in.wr_en && req_in.addr == rvsr_pkg::SETPOINT_ADDR
		&& req_in.wdata <= rvsr_pkg::FLOOR_TOP_CODE);
	cov_status_nowrite: cover property (
		req_in.wr_en && req_in.addr == rvsr_pkg::STATUS_ADDR);
endmodule

// >>> testbench/rvsr_host.sv
// host controller model issuing register strobes
`timescale 1ns/1ps
module rvsr_host (
	input wire logic clk_in,
	output rvsr_pkg::rvsr_req_t req_out
);
	// released address and data lines show inverted values, never a stale copy; both strobes drop low
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		req_out = '{w, ~w, a, d};
		@(posedge clk_in);
		#1;
		req_out = '{1'b0, 1'b0, ~a, ~d};
	endtask
	initial
	begin
		req_out = '0;
	end
endmodule

// >>> testbench/tb_rvsr_regs.sv
// self-checking bench for the setpoint and status registers
`timescale 1ns/1ps
module tb_rvsr_regs;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	rvsr_pkg::rvsr_req_t req;
	rvsr_pkg::rvsr_cond_t cond = '0;
	logic [7:0] rdata, vcode, got, c;
	logic rvalid;
	logic [11:0] mv;
	logic [7:0] corner [6] = '{8'h00, 8'h3B, 8'h3C, 8'h7F, 8'h80, 8'hFF};
	int fail_count = 0, check_count = 0, seed = 97885, cycles = 0;
	rvsr_regs u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.req_in(req), .cond_in(cond), .rdata_out(rdata),
		.rvalid_out(rvalid), .voltage_code_out(vcode),
		.target_mv_out(mv));
	rvsr_host u_host (.clk_in(ref_clk_in), .req_out(req));
	// ----
	// helpers
	// ----
	initial
	begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	function automatic logic [11:0] exp_mv(input logic [7:0] k);
		if (k <= 8'h3B)
			return 12'h258;
		if (k < 8'h80)
			return 12'h262 + 12'(k - 8'h3C) * 12'h00A;
		return 12'h514 + 12'(k - 8'h80) * 12'h014;
	endfunction
	task automatic chk(input string n, input logic [11:0] e,
		input logic [11:0] g);
		check_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 8'hA5);
		chk("rvalid", 12'h001, {11'h000, rvalid});
		got = rdata;
	endtask
	// three edges: code lands after the first (inside xfer), decoded target after the second, then one more
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d);
		repeat (2) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	// ----
	// tests
	// ----
	initial
	begin
		repeat (16) @(posedge ref_clk_in);
		#1;
		reset_in = 1'b0;
		chk("voltage_code", 12'h000, {4'h0, vcode});
		chk("target_mv", 12'h258, mv);
		rd(8'h03);
		chk("status", 12'h000, {4'h0, got});
		$display("test reset done");
		for (int i = 0; i < 40; i++)
		begin
			c = (i < 6) ? corner[i] : 8'($random(seed));
			wr(8'h02, c);
			chk("voltage_code", {4'h0, c}, {4'h0, vcode});
			chk("target_mv", exp_mv(c), mv);
			rd(8'h02);
			chk("setpoint", {4'h0, c}, {4'h0, got});
		end
		$display("test setpoint done");
		for (int i = 0; i < 24; i++)
		begin
			c = (i < 8) ? 8'h01 << i : 8'($random(seed));
			cond = c;
			repeat (3) @(posedge ref_clk_in);
			#1;
			wr(8'h03, ~c);
			rd(8'h03);
			chk("status", {4'h0, c}, {4'h0, got});
			rd(8'h10);
			chk("unmapped", 12'h000, {4'h0, got});
		end
		$display("test status done");
		wrap_up();
	end
endmodule
